// ### rtl/sleep_wake_map.vh
`ifndef SLEEP_WAKE_MAP_VH
`define SLEEP_WAKE_MAP_VH
`define SW_NUM_IRQ          8
`define SW_NUM_IO           12
`define SW_ST_AWAKE         3'h0
`define SW_ST_ENTER         3'h1
`define SW_ST_ASLEEP        3'h2
`define SW_ST_STAB          3'h3
`define SW_ST_RESUME        3'h4
`define SW_ST_RESET         3'h5
`define SW_STAB_NS          20000
`define SW_CLK_MHZ          250
`define SW_STAB_CYC         ((`SW_STAB_NS * `SW_CLK_MHZ) / 1000)
`define SW_RESET_HOLD_CYC   4
`define SW_VECTOR_ADDR      16'h0004
`endif

// ### rtl/wake_sync.v
`default_nettype none
// two-stage synchroniser for a bus of asynchronous levels
module wake_sync #(
   parameter W = 1
) (
   input  wire         clk_sys,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_r;

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_r <= {W{1'b0}};
         q      <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // wake_sync
`default_nettype wire

// ### rtl/wake_request.v
`default_nettype none
module wake_request #(
   parameter N = 8
) (
   input  wire [N-1:0] irq_flag,
   input  wire [N-1:0] irq_enable,
   output wire         wake
);
   // combinational so it works with the cpu clock gated off
   assign wake = |(irq_flag & irq_enable);
endmodule // wake_request
`default_nettype wire

// ### rtl/sleep_wake_control.v
`include "sleep_wake_map.vh"
`default_nettype none
module sleep_wake_control #(
   parameter N_IRQ       = `SW_NUM_IRQ,
   parameter N_IO        = `SW_NUM_IO,
   parameter UNREGULATED = 0,
   parameter STAB_CYC    = `SW_STAB_CYC
) (
   input  wire              clk_sys,
   input  wire              rst_n,
   input  wire              sleep_instr,
   input  wire              clrwdt_instr,
   input  wire [15:0]       pc,
   input  wire              global_irq_enable,
   input  wire [N_IRQ-1:0]  irq_event,
   input  wire [N_IRQ-1:0]  irq_enable,
   input  wire [N_IRQ-1:0]  irq_flag_clear,
   input  wire [N_IRQ-1:0]  irq_sleep_capable,
   input  wire              master_clear_input,
   input  wire              master_clear_enable,
   input  wire              brownout_reset,
   input  wire              brownout_enable,
   input  wire              power_on_reset,
   input  wire              watchdog_timeout,
   input  wire              watchdog_sleep_enable,
   input  wire              regulator_sleep_power_select,
   input  wire              lp_incompatible_active,
   input  wire              timer1_src_lfosc,
   input  wire              timer1_src_ext,
   input  wire              adc_src_rc,
   input  wire [N_IO-1:0]   io_out_cpu,
   input  wire [N_IO-1:0]   io_oe_n_cpu,
   output reg               cpu_clk_en,
   output reg               low_freq_internal_osc_en,
   output reg               timer1_run,
   output reg               adc_run,
   output reg               watchdog_clear,
   output reg               watchdog_run,
   output reg               power_down_flag,
   output reg               watchdog_expiry_flag,
   output reg  [N_IRQ-1:0]  irq_flag,
   output reg               regulator_low_power,
   output reg               device_reset,
   output reg               sleeping,
   output reg               fetch_req,
   output reg  [15:0]       fetch_addr,
   output reg               vector_req,
   output reg  [15:0]       vector_addr,
   output reg  [N_IO-1:0]   io_out,
   output reg  [N_IO-1:0]   io_oe_n
);
   localparam ST_AWAKE  = `SW_ST_AWAKE;
   localparam ST_ENTER  = `SW_ST_ENTER;
   localparam ST_ASLEEP = `SW_ST_ASLEEP;
   localparam ST_STAB   = `SW_ST_STAB;
   localparam ST_RESUME = `SW_ST_RESUME;
   localparam ST_RESET  = `SW_ST_RESET;
   localparam [31:0] HOLD_CYC = `SW_RESET_HOLD_CYC;

   // asynchronous sources pass two flops first
   wire [N_IRQ-1:0] irq_event_s;
   wire [3:0]       rst_src_s;
   wire             master_clear_input_s;
   wire             bor_s;
   wire             por_s;
   wire             wdt_s;
   wire             wake_irq;
   wire             reset_wake;

   wake_sync #(.W(N_IRQ)) u_irq_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (irq_event),
      .q       (irq_event_s)
   );

   // the external interrupt pin arrives as one of the irq events
   wake_sync #(.W(4)) u_rst_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({master_clear_input, brownout_reset, power_on_reset, watchdog_timeout}),
      .q       (rst_src_s)
   );

   assign master_clear_input_s = rst_src_s[3];
   assign bor_s  = rst_src_s[2];
   assign por_s  = rst_src_s[1];
   assign wdt_s  = rst_src_s[0];

   // only sources that can run while asleep are allowed to wake it
   wire [N_IRQ-1:0] wake_en;
   assign wake_en = irq_enable & irq_sleep_capable;

   wake_request #(.N(N_IRQ)) u_wake (
      .irq_flag   (irq_flag),
      .irq_enable (wake_en),
      .wake       (wake_irq)
   );

   // reset sources act in every state except ST_RESUME, which always moves on to ST_AWAKE
   assign reset_wake = (master_clear_input_s & master_clear_enable) | (bor_s & brownout_enable) | por_s;

   reg [2:0]  state_r;
   reg [2:0]  state_nxt;
   reg [31:0] cnt_r;
   reg        pend_vec_r;
   reg        lp_sel_r;
   reg        wdt_wake_r;
   wire       pending_now;

   // a flag that is enabled and already set turns sleep into a no-op
   assign pending_now = |(irq_flag & irq_enable);

   // set wins over clear
   always @(posedge clk_sys) begin
      if (!rst_n)
         irq_flag <= {N_IRQ{1'b0}};
      else
         irq_flag <= (irq_flag & ~irq_flag_clear) | irq_event_s;
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_AWAKE: begin
            if (reset_wake)
               state_nxt = ST_RESET;
            else if (sleep_instr && !pending_now)
               state_nxt = ST_ENTER;
         end
         ST_ENTER: begin
            if (reset_wake)
               state_nxt = ST_RESET;
            else if (wake_irq)
               state_nxt = ST_RESUME;
            else
               state_nxt = ST_ASLEEP;
         end
         ST_ASLEEP: begin
            if (reset_wake)
               state_nxt = ST_RESET;
            else if (wake_irq || (wdt_s && watchdog_sleep_enable))
               state_nxt = lp_sel_r ? ST_STAB : ST_RESUME;
         end
         ST_STAB: begin
            if (reset_wake)
               state_nxt = ST_RESET;
            else if (cnt_r >= STAB_CYC - 1)
               state_nxt = ST_RESUME;
         end
         ST_RESUME: state_nxt = ST_AWAKE;
         ST_RESET: begin
            if (!reset_wake && cnt_r >= HOLD_CYC - 1)
               state_nxt = ST_AWAKE;
         end
         default: state_nxt = ST_AWAKE;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r                  <= ST_AWAKE;
         cnt_r                    <= 32'h0;
         pend_vec_r               <= 1'b0;
         lp_sel_r                 <= 1'b0;
         wdt_wake_r               <= 1'b0;
         cpu_clk_en               <= 1'b1;
         low_freq_internal_osc_en <= 1'b1;
         timer1_run               <= 1'b1;
         adc_run                  <= 1'b1;
         watchdog_clear           <= 1'b1;
         watchdog_run             <= 1'b0;
         power_down_flag          <= 1'b1;
         watchdog_expiry_flag     <= 1'b1;
         regulator_low_power      <= 1'b0;
         device_reset             <= 1'b1;
         sleeping                 <= 1'b0;
         fetch_req                <= 1'b0;
         fetch_addr               <= 16'h0;
         vector_req               <= 1'b0;
         vector_addr              <= 16'h0;
         io_out                   <= {N_IO{1'b0}};
         io_oe_n                  <= {N_IO{1'b1}};
      end else begin
         state_r        <= state_nxt;
         cnt_r          <= (state_nxt == state_r) ? cnt_r + 32'h1 : 32'h0;
         watchdog_clear <= clrwdt_instr;
         fetch_req      <= 1'b0;
         vector_req     <= 1'b0;
         device_reset   <= (state_nxt == ST_RESET);
         low_freq_internal_osc_en <= 1'b1;
         watchdog_run   <= sleeping ? watchdog_sleep_enable : 1'b1;
         if (state_r == ST_AWAKE && state_nxt == ST_ENTER) begin
            watchdog_clear       <= 1'b1;
            power_down_flag      <= 1'b0;
            watchdog_expiry_flag <= 1'b1;
            fetch_req            <= 1'b1;
            fetch_addr           <= pc + 16'h1;
            pend_vec_r           <= global_irq_enable;
            // low-power select ignored when unregulated or a peripheral needs full regulation
            lp_sel_r             <= (UNREGULATED == 0) && regulator_sleep_power_select
                                    && !lp_incompatible_active;
            io_out               <= io_out_cpu;
            io_oe_n              <= io_oe_n_cpu;
         end
         if (state_nxt == ST_ENTER || state_nxt == ST_ASLEEP || state_nxt == ST_STAB) begin
            cpu_clk_en <= 1'b0;
            sleeping   <= 1'b1;
            timer1_run <= timer1_src_lfosc | timer1_src_ext;
            adc_run    <= adc_src_rc;
            regulator_low_power <= (state_nxt != ST_STAB) && lp_sel_r;
         end else begin
            cpu_clk_en <= 1'b1;
            sleeping   <= 1'b0;
            timer1_run <= 1'b1;
            adc_run    <= 1'b1;
            regulator_low_power <= 1'b0;
            io_out     <= io_out_cpu;
            io_oe_n    <= io_oe_n_cpu;
         end
         if (state_r == ST_ASLEEP && state_nxt != ST_ASLEEP)
            wdt_wake_r <= wdt_s && !wake_irq && !reset_wake;
         if (state_nxt == ST_RESUME) begin
            watchdog_clear <= 1'b1;
            // the remembered cause only counts after a stabilisation wait, never on an early irq wake
            if ((state_r == ST_STAB && wdt_wake_r) || (state_r == ST_ASLEEP && wdt_s && !wake_irq))
               watchdog_expiry_flag <= 1'b0;
         end
         if (state_r == ST_RESUME && pend_vec_r) begin
            vector_req  <= 1'b1;
            vector_addr <= `SW_VECTOR_ADDR;
         end
         if (state_nxt == ST_RESET) begin
            watchdog_clear       <= 1'b1;
            power_down_flag      <= 1'b1;
            watchdog_expiry_flag <= 1'b1;
            pend_vec_r           <= 1'b0;
         end
      end
   end
endmodule // sleep_wake_control
`default_nettype wire

// ### tb/sleep_wake_props.sv
`default_nettype none
module sleep_wake_props #(
   parameter N_IRQ = 8,
   parameter N_IO  = 12
) (
   input wire logic             clk_sys,
   input wire logic             rst_n,
   input wire logic             sleep_instr,
   input wire logic [15:0]      pc,
   input wire logic [N_IRQ-1:0] irq_enable,
   input wire logic [N_IRQ-1:0] irq_flag,
   input wire logic             cpu_clk_en,
   input wire logic             watchdog_clear,
   input wire logic             power_down_flag,
   input wire logic             watchdog_expiry_flag,
   input wire logic             device_reset,
   input wire logic             sleeping,
   input wire logic             fetch_req,
   input wire logic [15:0]      fetch_addr,
   input wire logic             vector_req,
   input wire logic [15:0]      vector_addr,
   input wire logic [N_IO-1:0]  io_out,
   input wire logic [N_IO-1:0]  io_oe_n
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   sequence s_enter;
      !sleeping ##1 sleeping;
   endsequence
   sequence s_wake;
      sleeping ##1 !sleeping;
   endsequence
   entry_flags_a: assert property (s_enter |-> !power_down_flag && watchdog_expiry_flag)
      else $error("entry flags wrong");
   entry_fetch_a: assert property (s_enter |-> fetch_req && fetch_addr == $past(pc) + 16'h0001)
      else $error("prefetch address wrong");
   entry_wdt_a: assert property (s_enter |-> watchdog_clear)
      else $error("watchdog not cleared on entry");
   clock_stop_a: assert property (sleeping |-> !cpu_clk_en)
      else $error("cpu clock runs in sleep");
   pin_hold_a: assert property (sleeping && $past(sleeping) |-> $stable(io_out) && $stable(io_oe_n))
      else $error("pin state moved in sleep");
   // a reset wake clears the watchdog through the reset itself
   wake_wdt_a: assert property (s_wake |-> ##[0:2] (watchdog_clear || device_reset))
      else $error("watchdog not cleared on wake");
   vector_addr_a: assert property (vector_req |-> vector_addr == 16'h0004 && $past(cpu_clk_en))
      else $error("bad vector");
   sleep_noop_a: assert property (sleep_instr && cpu_clk_en && !sleeping && !device_reset &&
      |(irq_flag & irq_enable) |=> (!sleeping && !fetch_req && !watchdog_clear && $stable(power_down_flag)) [*2])
      else $error("refused sleep took effect");
   reset_hold_a: assert property ($rose(device_reset) |-> device_reset [*4])
      else $error("device reset too short");
endmodule // sleep_wake_props
bind sleep_wake_control sleep_wake_props #(.N_IRQ(N_IRQ), .N_IO(N_IO)) props_i (.*);
`default_nettype wire

// ### tb/wake_partner.sv
`default_nettype none
module wake_partner (
   input  wire logic       clk_sys,
   input  wire logic       go,
   input  wire logic [2:0] src,
   output wire logic [7:0] irq_event,
   output wire logic       watchdog_timeout,
   output wire logic       master_clear_input,
   output wire logic       brownout_reset,
   output wire logic       power_on_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] hold_r = 2'h0;
   logic [2:0] src_r  = 3'h0;
   wire        on     = hold_r != 2'h0;
   // three-cycle pulses so the two-flop synchronisers cannot miss them
   always @(posedge clk_sys) begin
      if (go) begin
         hold_r <= 2'h3;
         src_r  <= src;
      end else if (on) begin
         hold_r <= hold_r - 2'h1;
      end
   end
   assign irq_event          = (on && src_r < 3'h2) ? 8'h01 << src_r : 8'h00;
   assign watchdog_timeout   = on && src_r == 3'h2;
   assign master_clear_input = on && src_r == 3'h3;
   assign brownout_reset     = on && src_r == 3'h4;
   assign power_on_reset     = on && src_r == 3'h5;
endmodule // wake_partner
`default_nettype wire

// ### tb/sleep_wake_control_tb.sv
`default_nettype none
module sleep_wake_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STAB = 8;
   logic        clk_sys = 1'b0, rst_n = 1'b0, sleep_instr = 1'b0, clrwdt_instr = 1'b0, go = 1'b0;
   logic        global_irq_enable = 1'b0, master_clear_enable = 1'b1, brownout_enable = 1'b1;
   logic        watchdog_sleep_enable = 1'b1, regulator_sleep_power_select = 1'b0, lp_incompatible_active = 1'b0;
   logic        timer1_src_lfosc = 1'b0, timer1_src_ext = 1'b0, adc_src_rc = 1'b0, pd;
   logic [2:0]  src = 3'h0;
   logic [15:0] pc = 16'h0000, fetch_addr, vector_addr, a_seen;
   logic [7:0]  irq_enable = 8'h00, irq_flag_clear = 8'h00, irq_sleep_capable = 8'hff, irq_event, irq_flag;
   logic [11:0] io_out_cpu = 12'h000, io_oe_n_cpu = 12'hfff, io_out, io_oe_n;
   logic        master_clear_input, brownout_reset, power_on_reset, watchdog_timeout, cpu_clk_en, timer1_run;
   logic        low_freq_internal_osc_en, adc_run, watchdog_clear, watchdog_run, power_down_flag, device_reset;
   logic        watchdog_expiry_flag, regulator_low_power, sleeping, fetch_req, vector_req;
   logic [18:0] exp_q[$];
   logic [31:0] seed = 32'he8b768c6;
   int          bad_count = 0, checks = 0, lat[2];

   sleep_wake_control #(.STAB_CYC(STAB)) uut (.*);
   wake_partner wp (.*);
   always #2 clk_sys = ~clk_sys;
   assign a_seen = vector_req ? vector_addr : fetch_addr;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string what, input logic [18:0] seen, input logic [18:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // outputs are looked at mid-cycle, well clear of the edge that launches them
   always @(negedge clk_sys) begin
      if (rst_n && (fetch_req === 1'b1 || vector_req === 1'b1)) begin
         if (exp_q.size() == 0) chk("spare", 19'h1, 19'h0);
         else chk("result", {vector_req, power_down_flag, watchdog_expiry_flag, a_seen}, exp_q.pop_front());
      end
   end

   task automatic run(input logic [2:0] c, input logic g, input logic lp, input logic inc);
      int n;
      logic w;
      logic [23:0] pins;
      n = 0;
      seed = lfsr(seed);
      // the watchdog wake needs the watchdog running in sleep
      w = (c == 3'h2) | seed[19];
      pins = {io_out_cpu, io_oe_n_cpu};
      @(posedge clk_sys);
      pc <= seed[15:0];
      watchdog_sleep_enable <= w;
      global_irq_enable <= g;
      regulator_sleep_power_select <= lp;
      lp_incompatible_active <= inc;
      {timer1_src_lfosc, timer1_src_ext, adc_src_rc} <= seed[18:16];
      irq_enable <= 8'h03;
      sleep_instr <= 1'b1;
      exp_q.push_back({3'b001, seed[15:0] + 16'h0001});
      @(posedge clk_sys);
      sleep_instr <= 1'b0;
      {io_out_cpu, io_oe_n_cpu} <= seed[31:8];
      repeat (4) @(negedge clk_sys);
      chk("sleep", {sleeping, timer1_run, adc_run}, {1'b1, seed[18] | seed[17], seed[16]});
      chk("clock", {cpu_clk_en, low_freq_internal_osc_en}, 2'b01);
      chk("regulator", {watchdog_run, regulator_low_power}, {w, lp & ~inc});
      chk("pin out", io_out, pins[23:12]);
      chk("pin oe", io_oe_n, pins[11:0]);
      if (g && c < 3'h2) exp_q.push_back({3'b101, 16'h0004});
      @(posedge clk_sys);
      src <= c;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      while (cpu_clk_en !== 1'b1 && device_reset !== 1'b1 && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      if (c < 3'h2 && !inc) lat[lp] = n;
      chk("wake", {n < 200, device_reset}, {1'b1, c > 3'h2});
      n = 0;
      while (device_reset !== 1'b0 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      repeat (5) @(negedge clk_sys);
      chk("flags", {n < 50, power_down_flag, watchdog_expiry_flag, sleeping}, {1'b1, c > 3'h2, c != 3'h2, 1'b0});
      @(posedge clk_sys);
      irq_flag_clear <= 8'hff;
      @(posedge clk_sys);
      irq_flag_clear <= 8'h00;
      $display("test %0d done", c);
   endtask

   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("reset", {power_down_flag, watchdog_expiry_flag, device_reset, cpu_clk_en}, 4'hd);
      run(3'h0, 1'b0, 1'b0, 1'b0);
      run(3'h1, 1'b1, 1'b1, 1'b0);
      run(3'h0, 1'b1, 1'b1, 1'b1);
      for (int i = 2; i < 6; i++) run(3'(i), 1'b0, 1'b0, 1'b0);
      chk("stab", lat[1] >= lat[0] + STAB, 1'b1);
      @(posedge clk_sys);
      irq_enable <= 8'h00;
      src <= 3'h0;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (8) @(negedge clk_sys);
      chk("flag", irq_flag, 8'h01);
      pd = power_down_flag;
      @(posedge clk_sys);
      irq_enable <= 8'h01;
      global_irq_enable <= 1'b0;
      sleep_instr <= 1'b1;
      @(posedge clk_sys);
      sleep_instr <= 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("noop", {sleeping, power_down_flag}, {1'b0, pd});
      $display("test refuse done");
      chk("queue", 19'(exp_q.size()), 19'h0);
      end_sim();
   end

   initial begin
      #50000; // several times the longest expected run
      bad_count++;
      end_sim();
   end
endmodule // sleep_wake_control_tb
`default_nettype wire
